//--- bus_sizing_pkg.sv
/*
 * Shared constants and types for the bus sizing and alignment sequencer.
 * Assumes a 32-bit data bus organised as four byte lanes per dword.
 */
package bus_sizing_pkg;

	// ==========================================================
	// Geometry
	localparam int        LANES       = 4;
	localparam int        FILL_DWORDS = 4;
	localparam logic [3:0] LANES_ALL  = 4'hf;
	localparam logic [3:0] LANES_NONE = 4'h0;
	localparam logic [3:0] LOW_HALF   = 4'h3;
	localparam logic [3:0] HIGH_HALF  = 4'hc;

	// ==========================================================
	// Reset values
	localparam logic [3:0] RST_ENABLES_N = 4'hf;
	localparam logic       RST_READY     = 1'b1;

	// ==========================================================
	// Operand length and sequencer states
	typedef enum logic [1:0]
	{
		LEN_BYTE  = 2'h0,
		LEN_WORD  = 2'h1,
		LEN_DWORD = 2'h2
	} len_type;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_ISSUE = 2'h1,
		ST_WAIT  = 2'h3
	} state_type;

endpackage

//--- operand_splitter.sv
/*
 * Splits a logical operand into the byte lanes it occupies in its own
 * dword and in the following dword. Purely combinational; the caller
 * registers whatever it keeps.
 */
module operand_splitter #(
	parameter int LANES = bus_sizing_pkg::LANES
)(
	input  wire logic [1:0] addr_low,
	input  wire logic [1:0] len,
	output logic      [3:0] low_mask,
	output logic      [3:0] high_mask
);

	// ==========================================================
	// Elaboration check
	if (LANES != 4)
	begin : g_bad_lanes
		$error("operand_splitter serves exactly four byte lanes");
	end

	logic [7:0] span;

	// ==========================================================
	// Lane mask of the operand shifted to its start lane
	always_comb
	begin
		case (len)
			bus_sizing_pkg::LEN_BYTE:  span = 8'h01;
			bus_sizing_pkg::LEN_WORD:  span = 8'h03;
			bus_sizing_pkg::LEN_DWORD: span = 8'h0f;
			default:                   span = 8'h01;
		endcase
		span      = span << addr_low;
		low_mask  = span[3:0];
		high_mask = span[7:4];
	end

endmodule

//--- dynamic_bus_sizing_align.sv
/*
 * Bus cycle sequencer: splits operands and line fills into bus cycles
 * by dword alignment and by the narrow-bus size answer of each cycle.
 * Assumes the outside system answers each cycle with bus_ready and
 * presents the size inputs with it; address decode for 16-bit slaves
 * and byte swapping live outside this block.
 */
// Function
// - Never issue byte enables with gaps between asserted enables.
// - Accept narrow sizes during line fills; up to 16 byte cycles.
// - Later line fill cycles enable exactly the bytes still outstanding.
// - Dwords start at multiples of four; crossing one costs extra cycles.
// - Alignment split moves the highest-order bytes first.
// - Dword at offset 11 goes as three upper bytes, then lowest byte.
// - Narrow size answers move lower-order bytes or words first.
// - Aligned dword on 16-bit bus: lower two bytes, then upper two.
// - Three-byte cycle on 16-bit bus: lower word, then upper byte (lanes 1-3: lower byte, then upper word).
// - 32-bit bus: byte one cycle, word one or two, dword one or two.
// - 8-bit bus moves every byte in its own cycle.
module dynamic_bus_sizing_align #(
	parameter int FILL_DWORDS = bus_sizing_pkg::FILL_DWORDS
)(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        req_valid,
	input  wire logic [31:0] req_addr,
	input  wire logic [1:0]  req_len,
	input  wire logic        req_fill,
	output logic             req_ready,
	output logic             bus_start,
	output logic      [29:0] bus_addr,
	output logic      [3:0]  byte_lane_enables_n,
	input  wire logic        bus_ready,
	input  wire logic        size_eight_n,
	input  wire logic        size_sixteen_n,
	output logic             op_done
);

	// ==========================================================
	// Elaboration check: line must be a power of two, at most 4 dwords
	if (FILL_DWORDS != 1 && FILL_DWORDS != 2 && FILL_DWORDS != 4)
	begin : g_bad_fill
		$error("FILL_DWORDS must be 1, 2 or 4");
	end

	localparam logic [29:0] WRAP = 30'(FILL_DWORDS - 1);

	// ==========================================================
	// Helpers
	function automatic logic [3:0] lowest_lane(input logic [3:0] m);
		lowest_lane = m & 4'(~m + 4'h1);
	endfunction

	// Lanes moved by one cycle given the size answer
	function automatic logic [3:0] moved(input logic [3:0] pend,
		input logic s8_n, input logic s16_n);
		if (!s8_n)
			moved = lowest_lane(pend);
		else if (!s16_n)
			moved = ((pend & bus_sizing_pkg::LOW_HALF) != 4'h0) ?
				(pend & bus_sizing_pkg::LOW_HALF) :
				(pend & bus_sizing_pkg::HIGH_HALF);
		else
			moved = pend;
	endfunction

	function automatic logic contiguous(input logic [3:0] m);
		contiguous = (m == 4'h1) || (m == 4'h2) || (m == 4'h4) ||
			(m == 4'h8) || (m == 4'h3) || (m == 4'h6) ||
			(m == 4'hc) || (m == 4'h7) || (m == 4'he) || (m == 4'hf);
	endfunction

	// ==========================================================
	// State
	bus_sizing_pkg::state_type state_ff, nxt_state;
	logic [3:0]  pend_ff, nxt_pend;
	logic [3:0]  later_ff, nxt_later;
	logic [29:0] dw_ff, nxt_dw;
	logic [2:0]  fill_left_ff, nxt_fill_left;
	logic        fill_ff, nxt_fill;
	logic        start_ff, nxt_start;
	logic [3:0]  be_n_ff, nxt_be_n;
	logic        ready_ff, nxt_ready;
	logic        done_ff, nxt_done;
	logic [3:0]  low_mask, high_mask, rest;
	logic        go;

	operand_splitter #(.LANES(bus_sizing_pkg::LANES)) i_operand_splitter (
		.addr_low  (req_addr[1:0]),
		.len       (req_len),
		.low_mask  (low_mask),
		.high_mask (high_mask)
	);

	always_comb
	begin
		nxt_state     = state_ff;
		nxt_pend      = pend_ff;
		nxt_later     = later_ff;
		nxt_dw        = dw_ff;
		nxt_fill_left = fill_left_ff;
		nxt_fill      = fill_ff;
		nxt_ready     = ready_ff;
		nxt_done      = 1'b0;
		go            = 1'b0;
		rest          = pend_ff & ~moved(pend_ff, size_eight_n,
			size_sixteen_n);
		case (state_ff)
			bus_sizing_pkg::ST_IDLE:
			begin
				if (req_valid)
				begin
					go        = 1'b1;
					nxt_ready = 1'b0;
					nxt_dw    = req_addr[31:2];
					nxt_later = bus_sizing_pkg::LANES_NONE;
					if (req_fill)
					begin
						// Whole line, every lane of the first dword
						nxt_pend      = bus_sizing_pkg::LANES_ALL;
						nxt_fill      = 1'b1;
						nxt_fill_left = 3'(FILL_DWORDS - 1);
					end
					else if (high_mask != bus_sizing_pkg::LANES_NONE)
					begin
						// Dword crossing: upper dword goes first
						nxt_pend  = high_mask;
						nxt_later = low_mask;
						nxt_dw    = 30'(req_addr[31:2] + 30'h1);
					end
					else
						nxt_pend = low_mask;
				end
			end
			bus_sizing_pkg::ST_ISSUE:
				nxt_state = bus_sizing_pkg::ST_WAIT;
			bus_sizing_pkg::ST_WAIT:
			begin
				if (bus_ready)
				begin
					go = 1'b1;
					if (rest != bus_sizing_pkg::LANES_NONE)
						nxt_pend = rest;
					else if (later_ff != bus_sizing_pkg::LANES_NONE)
					begin
						nxt_pend  = later_ff;
						nxt_later = bus_sizing_pkg::LANES_NONE;
						nxt_dw    = 30'(dw_ff - 30'h1);
					end
					else if (fill_ff && fill_left_ff != 3'h0)
					begin
						// Next dword of the line, wrapping inside it
						nxt_pend      = bus_sizing_pkg::LANES_ALL;
						nxt_fill_left = 3'(fill_left_ff - 3'h1);
						nxt_dw        = (dw_ff & ~WRAP) |
							(30'(dw_ff + 30'h1) & WRAP);
					end
					else
					begin
						go        = 1'b0;
						nxt_state = bus_sizing_pkg::ST_IDLE;
						nxt_ready = 1'b1;
						nxt_done  = 1'b1;
						nxt_fill  = 1'b0;
					end
				end
			end
			default:
			begin
				nxt_state = bus_sizing_pkg::ST_IDLE;
				nxt_ready = 1'b1;
			end
		endcase
		nxt_start = go;
		if (go)
			nxt_state = bus_sizing_pkg::ST_ISSUE;
		// Enables change when a cycle starts and return to all high (RST_ENABLES_N) in idle
		nxt_be_n = go ? ~nxt_pend : be_n_ff;
		if (nxt_state == bus_sizing_pkg::ST_IDLE)
			nxt_be_n = bus_sizing_pkg::RST_ENABLES_N;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_ff     <= bus_sizing_pkg::ST_IDLE;
			pend_ff      <= bus_sizing_pkg::LANES_NONE;
			later_ff     <= bus_sizing_pkg::LANES_NONE;
			dw_ff        <= 30'h0;
			fill_left_ff <= 3'h0;
			fill_ff      <= 1'b0;
			start_ff     <= 1'b0;
			be_n_ff      <= bus_sizing_pkg::RST_ENABLES_N;
			ready_ff     <= bus_sizing_pkg::RST_READY;
			done_ff      <= 1'b0;
		end
		else
		begin
			state_ff     <= nxt_state;
			pend_ff      <= nxt_pend;
			later_ff     <= nxt_later;
			dw_ff        <= nxt_dw;
			fill_left_ff <= nxt_fill_left;
			fill_ff      <= nxt_fill;
			start_ff     <= nxt_start;
			be_n_ff      <= nxt_be_n;
			ready_ff     <= nxt_ready;
			done_ff      <= nxt_done;
		end
	end

	assign req_ready           = ready_ff;
	assign bus_start           = start_ff;
	assign bus_addr            = dw_ff;
	assign byte_lane_enables_n = be_n_ff;
	assign op_done             = done_ff;

	// ==========================================================
	// Checks
	logic [4:0] fill_cycles_ff;
	logic       accept;

	assign accept = req_valid && state_ff == bus_sizing_pkg::ST_IDLE;

	// Counts cycles of the running line fill
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !fill_ff)
			fill_cycles_ff <= 5'h0;
		else if (start_ff)
			fill_cycles_ff <= 5'(fill_cycles_ff + 5'h1);
	end

	be_contiguous_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		bus_start |-> contiguous(~byte_lane_enables_n))
		else $error("byte enables with a gap issued");

	fill_limit_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		fill_cycles_ff <= 5'(FILL_DWORDS * 4))
		else $error("line fill used too many cycles");

	fill_first_all_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		accept && req_fill |=> bus_start && byte_lane_enables_n == 4'h0)
		else $error("line fill did not open with all lanes");

	high_first_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		accept && !req_fill && req_len == bus_sizing_pkg::LEN_DWORD &&
		req_addr[1:0] == 2'h3
		|=> bus_start && byte_lane_enables_n == 4'h8 &&
		bus_addr == 30'($past(req_addr[31:2]) + 30'h1))
		else $error("unaligned dword did not start with upper bytes");

	crossing_two_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		state_ff == bus_sizing_pkg::ST_WAIT && bus_ready &&
		size_eight_n && size_sixteen_n &&
		later_ff != 4'h0 && !fill_ff
		|=> bus_start && bus_addr == 30'($past(dw_ff) - 30'h1))
		else $error("lower dword of split operand not next");

	sixteen_low_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		state_ff == bus_sizing_pkg::ST_WAIT && bus_ready &&
		size_eight_n && !size_sixteen_n && byte_lane_enables_n == 4'h0
		|=> bus_start && byte_lane_enables_n == 4'h3)
		else $error("16-bit answer did not leave the upper word");

	three_byte_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		state_ff == bus_sizing_pkg::ST_WAIT && bus_ready &&
		size_eight_n && !size_sixteen_n && byte_lane_enables_n == 4'h8
		|=> bus_start && byte_lane_enables_n == 4'hb ##1 !bus_start)
		else $error("three-byte cycle split wrongly on 16-bit bus");

	eight_single_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		state_ff == bus_sizing_pkg::ST_WAIT && bus_ready &&
		!size_eight_n && $countones(~byte_lane_enables_n) > 1
		|=> bus_start && $countones(~byte_lane_enables_n) ==
		$countones(~$past(byte_lane_enables_n)) - 1)
		else $error("8-bit answer moved more than one byte");

	aligned_one_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		accept && !req_fill && req_len == bus_sizing_pkg::LEN_DWORD &&
		req_addr[1:0] == 2'h0
		##2 bus_ready && size_eight_n && size_sixteen_n
		|=> op_done && req_ready)
		else $error("aligned dword on 32-bit bus took extra cycles");

endmodule

//--- narrow_bus_memory_model.sv
/*
 * Far-side model: an 8-, 16- or 32-bit memory that ends each bus cycle
 * after a random wait and answers with the size inputs of its width.
 * Assumes mode is set by the bench: 0 = 32-bit, 1 = 16-bit, 2 = 8-bit.
 */
module narrow_bus_memory_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       bus_start,
	input  wire logic [3:0] byte_lane_enables_n,
	input  wire logic [1:0] mode,
	output logic            bus_ready,
	output logic            size_eight_n,
	output logic            size_sixteen_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic flip_ff;
	logic word_sel;
	logic high_byte_strobe_n;
	logic low_byte_strobe_n;
	logic [1:0] swap_lane;

	// ==========================================================
	// 16-bit slave decode, no clock so it is valid with the address.
	// A line fill opens with every lane asserted, which is what the
	// slave has to assume for that first cycle anyway.
	assign word_sel           = byte_lane_enables_n[0] &
		byte_lane_enables_n[1];
	assign low_byte_strobe_n  = word_sel ? byte_lane_enables_n[2] :
		byte_lane_enables_n[0];
	assign high_byte_strobe_n = word_sel ? byte_lane_enables_n[3] :
		byte_lane_enables_n[1];

	// Processor lane that the slave's data byte 0 is swapped onto
	always_comb
	begin
		swap_lane = {word_sel, 1'b0};
		if (mode == 2'h2)
			for (int i = 3; i >= 0; i--)
				if (!byte_lane_enables_n[i])
					swap_lane = 2'(i);
	end

	// ==========================================================
	// Size answer; outside the ready clock the lines wander
	assign size_eight_n   = bus_ready ? (mode != 2'h2) : flip_ff;
	assign size_sixteen_n = bus_ready ? (mode != 2'h1) : ~flip_ff;

	always_ff @(posedge core_clk)
	begin
		flip_ff <= rst_n ? ~flip_ff : 1'b0;
	end

	always @(posedge core_clk)
	begin
		if (!rst_n)
			bus_ready <= 1'b0;
		else if (bus_start)
		begin
			repeat ($urandom_range(2)) @(posedge core_clk);
			bus_ready <= 1'b1;
			@(posedge core_clk);
			bus_ready <= 1'b0;
		end
	end
endmodule

//--- dynamic_bus_sizing_align_tb.sv
/*
 * Self-checking bench for the bus sizing sequencer: every length,
 * offset and bus width, line fills, back-to-back and held requests.
 * Assumes the far-side model in narrow_bus_memory_model.sv.
 */
module dynamic_bus_sizing_align_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int F = 4;

	logic        core_clk  = 1'b0;
	logic        rst_n     = 1'b0;
	logic        req_valid = 1'b0;
	logic [31:0] req_addr  = 32'h0;
	logic [1:0]  req_len   = 2'h0;
	logic        req_fill  = 1'b0;
	logic        req_ready;
	logic        bus_start;
	logic [29:0] bus_addr;
	logic [3:0]  byte_lane_enables_n;
	logic        bus_ready;
	logic        size_eight_n;
	logic        size_sixteen_n;
	logic        op_done;
	logic [1:0]  cur_mode  = 2'h0;
	logic [35:0] exp_q[$];
	logic [35:0] e;
	int          cnt_q[$];
	int          n_cyc     = 0;
	int          mismatches  = 0;
	int          check_count = 0;
	int          md, ln, off, k, nc;

	always #5 core_clk = ~core_clk;

	dynamic_bus_sizing_align #(.FILL_DWORDS(F)) i_dynamic_bus_sizing_align (
		.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_addr(req_addr), .req_len(req_len), .req_fill(req_fill),
		.req_ready(req_ready), .bus_start(bus_start), .bus_addr(bus_addr),
		.byte_lane_enables_n(byte_lane_enables_n), .bus_ready(bus_ready),
		.size_eight_n(size_eight_n), .size_sixteen_n(size_sixteen_n),
		.op_done(op_done));

	narrow_bus_memory_model i_narrow_bus_memory_model (
		.core_clk(core_clk), .rst_n(rst_n), .bus_start(bus_start),
		.byte_lane_enables_n(byte_lane_enables_n), .mode(cur_mode),
		.bus_ready(bus_ready), .size_eight_n(size_eight_n),
		.size_sixteen_n(size_sixteen_n));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Expected cycles: each issue carries all lanes still pending
	task automatic emit(input logic [29:0] d, input logic [3:0] m,
		input logic [1:0] w, inout int n);
		logic [3:0] t;
		while (m != 4'h0)
		begin
			exp_q.push_back({w, d, ~m});
			n++;
			t = (w == 2'h0) ? m : (w == 2'h2) ? 4'(m & (~m + 4'h1)) :
				((m & 4'h3) != 4'h0) ? (m & 4'h3) : (m & 4'hc);
			m = m & ~t;
		end
	endtask

	task automatic op(input logic [31:0] a, input int nb,
		input logic [1:0] w, input logic fl);
		logic [7:0] m;
		int         n;
		n = 0;
		m = 8'((8'h1 << nb) - 8'h1) << a[1:0];
		if (fl)
			for (int i = 0; i < F; i++)
				emit((a[31:2] & ~30'(F - 1)) |
					((a[31:2] + 30'(i)) & 30'(F - 1)), 4'hf, w, n);
		else
		begin
			emit(a[31:2] + 30'h1, m[7:4], w, n);
			emit(a[31:2], m[3:0], w, n);
		end
		cnt_q.push_back(n);
		req_valid <= 1'b1;
		req_addr  <= a;
		req_len   <= (nb == 1) ? bus_sizing_pkg::LEN_BYTE :
			(nb == 2) ? bus_sizing_pkg::LEN_WORD : bus_sizing_pkg::LEN_DWORD;
		req_fill  <= fl;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (req_ready !== 1'b1 && k < 400);
		// A request never taken means a hung sequencer
		if (req_ready !== 1'b1)
			mismatches++;
	endtask

	task automatic reset_check();
		check({req_ready, bus_start, op_done, byte_lane_enables_n,
			bus_addr},
			{bus_sizing_pkg::RST_READY, 2'h0,
			bus_sizing_pkg::RST_ENABLES_N, 30'h0});
	endtask

	// ==========================================================
	// Monitor: each bus cycle start takes the oldest expectation
	always @(posedge core_clk)
	begin
		if (rst_n && bus_start)
		begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
			cur_mode <= e[35:34];
			n_cyc++;
			check(bus_addr, e[33:4]);
			check(byte_lane_enables_n, e[3:0]);
		end
		if (rst_n && op_done)
		begin
			nc = (cnt_q.size() != 0) ? cnt_q.pop_front() : -1;
			check(n_cyc, nc);
			check(req_ready, 1'b1);
			n_cyc = 0;
		end
	end

	// Drops the held request at once: left up, it would be taken again
	// in the completion cycle of the last operation
	task automatic drain();
		req_valid <= 1'b0;
		k = 0;
		while (cnt_q.size() != 0 && k < 3000)
		begin
			@(posedge core_clk);
			k++;
		end
		check(cnt_q.size(), 0);
		check(exp_q.size(), 0);
		repeat (4) @(posedge core_clk);
	endtask

	initial
	begin
		repeat (30000) @(posedge core_clk);
		mismatches++;
		summarize();
	end

	initial
	begin
		void'($urandom(81319));
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		reset_check();
		@(posedge core_clk);
		rst_n <= 1'b1;
		// Requests stay held while busy, so each next one is refused
		// until the completion cycle and then taken back to back
		for (md = 0; md < 3; md++)
			for (ln = 0; ln < 3; ln++)
				for (off = 0; off < 4; off++)
					op({$urandom()} & ~32'h3 | 32'(off), 1 << ln, 2'(md), 1'b0);
		for (md = 0; md < 3; md++)
			op($urandom(), 4, 2'(md), 1'b1);
		repeat (10)
			op($urandom(), 1 << $urandom_range(2), 2'($urandom_range(2)),
				1'($urandom_range(1)));
		drain();
		rst_n <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		reset_check();
		@(posedge core_clk);
		rst_n <= 1'b1;
		op(32'h0000_0ffb, 4, 2'h2, 1'b0);
		drain();
		summarize();
	end
endmodule
